// [rtl/udc_defines.svh]
// Purpose: Constants for the up/down counter stage
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef UDC_DEFINES_SVH
`define UDC_DEFINES_SVH

// ********************************************
// Widths and values
// ********************************************
`define UDC_CNT_W 4
`define UDC_CNT_MAX 4'hf
`define UDC_CNT_ZERO 4'h0
`define UDC_CNT_ONE 4'h1
`define UDC_SYNC_W 8
// Idle levels: count pins high, load high, clear low, data low
`define UDC_SYNC_RST 8'he0
// Bit positions in the synchroniser bundle
`define UDC_SYNC_UP 7
`define UDC_SYNC_DOWN 6
`define UDC_SYNC_LOAD 5
`define UDC_SYNC_CLEAR 4

`endif

// [rtl/udc_pkg.sv]
// Purpose: Types for the up/down counter stage
// Assumes: Constants come from udc_defines.svh
// Notes: No timescale in packages
`include "udc_defines.svh"

package udc_pkg;

  // ********************************************
  // Types
  // ********************************************
  typedef logic [`UDC_CNT_W-1:0] udc_cnt_t;

  typedef enum logic [2:0] {
    UDC_ACT_HOLD = 3'b000,
    UDC_ACT_UP = 3'b001,
    UDC_ACT_DOWN = 3'b010,
    UDC_ACT_LOAD = 3'b011,
    UDC_ACT_CLEAR = 3'b100
  } udc_act_t;

endpackage

// [rtl/udc_sync.sv]
// Purpose: Two-stage synchroniser for a bundle of pin levels
// Assumes: Bits are independent levels
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns

module udc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // ********************************************
  // Two flops
  // ********************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// [rtl/udc_counter.sv]
// Purpose: Cascadable presettable 4-bit up/down binary counter stage
// Assumes: Pins are asynchronous to i_clk and held for at least three clocks
// Notes: Count pins idle high and count on their rising edge
//
// Overview of operation
// R01 - Four count bits update together each clock
// R02 - State advances only on count-pin rising edges
// R03 - Up pin increments, down pin decrements; other held high
// R04 - Load low copies parallel data into count
// R05 - Load acts without any count pulse
// R06 - Clear high forces zero over everything
// R07 - Borrow pulse width follows the down pulse
// R08 - Carry pulse width follows the up pulse
// R09 - Next stage takes borrow/carry as its count pins
// R10 - Count wraps modulo sixteen both ways
// R11 - Carry at all ones, up low; borrow at zero, down low
`timescale 1ns/1ns
`include "udc_defines.svh"

module udc_counter (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_count_up,
  input wire logic i_count_down,
  input wire logic i_load_n,
  input wire logic i_clear,
  input wire logic [3:0] i_data,
  output logic [3:0] o_q,
  output logic o_carry_n,
  output logic o_borrow_n
);

  // ********************************************
  // Pin synchronisation
  // ********************************************
  logic [`UDC_SYNC_W-1:0] pins_s;
  logic up_s;
  logic down_s;
  logic load_n_s;
  logic clear_s;
  udc_pkg::udc_cnt_t data_s;
  logic up_d_r;
  logic down_d_r;
  logic up_rise;
  logic down_rise;

  // Bundle skew between bits is tolerated; data is only taken while load stays low
  udc_sync #(
    .W(`UDC_SYNC_W),
    .RST_VAL(`UDC_SYNC_RST)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_count_up, i_count_down, i_load_n, i_clear, i_data}),
    .o_sync(pins_s)
  );

  assign up_s = pins_s[`UDC_SYNC_UP];
  assign down_s = pins_s[`UDC_SYNC_DOWN];
  assign load_n_s = pins_s[`UDC_SYNC_LOAD];
  assign clear_s = pins_s[`UDC_SYNC_CLEAR];
  assign data_s = pins_s[`UDC_CNT_W-1:0];

  // ********************************************
  // Edge detection
  // ********************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      up_d_r <= 1'b1;
      down_d_r <= 1'b1;
    end else begin
      up_d_r <= up_s;
      down_d_r <= down_s;
    end
  end

  assign up_rise = up_s & ~up_d_r; // R02
  assign down_rise = down_s & ~down_d_r; // R02

  // ********************************************
  // Action select
  // ********************************************
  udc_pkg::udc_act_t act;
  udc_pkg::udc_cnt_t cnt_r;
  udc_pkg::udc_cnt_t cnt_nxt;

  always_comb begin
    if (clear_s) begin
      act = udc_pkg::UDC_ACT_CLEAR; // R06
    end else if (!load_n_s) begin
      act = udc_pkg::UDC_ACT_LOAD; // R04
    end else if (up_rise && down_s) begin
      act = udc_pkg::UDC_ACT_UP; // R03
    end else if (down_rise && up_s) begin
      act = udc_pkg::UDC_ACT_DOWN; // R03
    end else begin
      // No rising edge, or an edge while the other pin is low, so nothing changes
      act = udc_pkg::UDC_ACT_HOLD;
    end
  end

  always_comb begin
    unique case (act)
      udc_pkg::UDC_ACT_CLEAR: cnt_nxt = `UDC_CNT_ZERO; // R06
      udc_pkg::UDC_ACT_LOAD: cnt_nxt = data_s; // R05
      udc_pkg::UDC_ACT_UP: cnt_nxt = cnt_r + `UDC_CNT_ONE; // R10
      udc_pkg::UDC_ACT_DOWN: cnt_nxt = cnt_r - `UDC_CNT_ONE; // R10
      udc_pkg::UDC_ACT_HOLD: cnt_nxt = cnt_r;
      default: cnt_nxt = cnt_r;
    endcase
  end

  // ********************************************
  // Count register
  // ********************************************
  // All four bits in one register, so outputs never ripple
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= `UDC_CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt; // R01
    end
  end

  assign o_q = cnt_r;

  // ********************************************
  // Carry and borrow
  // ********************************************
  // Active low so a following stage sees its rising edge as pulse end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_carry_n <= 1'b1;
      o_borrow_n <= 1'b1;
    end else begin
      o_carry_n <= ~((cnt_nxt == `UDC_CNT_MAX) & ~up_s); // R08 R11 R09
      o_borrow_n <= ~((cnt_nxt == `UDC_CNT_ZERO) & ~down_s); // R07 R11 R09
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  chk_clear_forces_zero: assert property ( // R06
    clear_s |=> (o_q == `UDC_CNT_ZERO)
  ) else $error("Clear did not force zero");

  chk_load_copies_data: assert property ( // R04
    (!clear_s && !load_n_s) |=> (o_q == $past(data_s))
  ) else $error("Load did not copy data");

  chk_load_beats_count: assert property ( // R05
    (!clear_s && !load_n_s && up_rise) |=> (o_q == $past(data_s))
  ) else $error("Count pulse disturbed load");

  chk_up_increments: assert property ( // R03
    (!clear_s && load_n_s && up_rise && down_s)
      |=> (o_q == 4'($past(o_q) + 4'h1))
  ) else $error("Up edge did not increment");

  chk_down_decrements: assert property ( // R03
    (!clear_s && load_n_s && down_rise && up_s)
      |=> (o_q == 4'($past(o_q) - 4'h1))
  ) else $error("Down edge did not decrement");

  chk_no_edge_holds: assert property ( // R02
    (!clear_s && load_n_s && !up_rise && !down_rise) |=> $stable(o_q)
  ) else $error("Count moved without an edge");

  chk_wrap_up_zero: assert property ( // R10
    (!clear_s && load_n_s && up_rise && down_s && o_q == 4'hf)
      |=> (o_q == 4'h0)
  ) else $error("Up count did not wrap to zero");

  chk_wrap_down_ones: assert property ( // R10
    (!clear_s && load_n_s && down_rise && up_s && o_q == 4'h0)
      |=> (o_q == 4'hf)
  ) else $error("Down count did not wrap to all ones");

  chk_carry_follows_up: assert property ( // R08
    (!clear_s && load_n_s && o_q == 4'hf && !up_s && $stable(o_q)) |-> ##1 !o_carry_n
  ) else $error("Carry missing while up pin low at all ones");

  chk_carry_cause: assert property ( // R11
    !o_carry_n |-> (o_q == 4'hf)
  ) else $error("Carry asserted away from all ones");

  chk_borrow_cause: assert property ( // R11
    !o_borrow_n |-> (o_q == 4'h0)
  ) else $error("Borrow asserted away from zero");

  chk_borrow_ends_rise: assert property ( // R07
    (!o_borrow_n && $rose(down_s)) |=> o_borrow_n
  ) else $error("Borrow outlived the down pulse");

  chk_borrow_follows_down: assert property ( // R07
    (!clear_s && load_n_s && o_q == 4'h0 && !down_s && $stable(o_q))
      |-> ##1 !o_borrow_n
  ) else $error("Borrow missing while down pin low at zero");

  chk_carry_ends_rise: assert property ( // R08
    (!o_carry_n && $rose(up_s)) |=> o_carry_n
  ) else $error("Carry outlived the up pulse");

  chk_clear_beats_load: assert property ( // R06
    (clear_s && !load_n_s) |=> (o_q == 4'h0)
  ) else $error("Load won over clear");

  chk_carry_needs_low: assert property ( // R11
    up_s |=> o_carry_n
  ) else $error("Carry asserted while up pin high");

  chk_borrow_needs_low: assert property ( // R11
    down_s |=> o_borrow_n
  ) else $error("Borrow asserted while down pin high");

  chk_q_one_step: assert property ( // R02
    (!clear_s && load_n_s) |=> ((o_q == $past(o_q))
      || (o_q == 4'($past(o_q) + 4'h1)) || (o_q == 4'($past(o_q) - 4'h1)))
  ) else $error("Count moved by more than one step");

endmodule

// [dv/udc_drv.sv]
// Purpose: Driving logic model for the counter stage pins
// Assumes: Tasks are called from the bench only
// Notes: Data lines show the inverse once load is released
`timescale 1ns/1ns

module udc_drv (
  input wire logic i_clk,
  input wire logic i_carry_n,
  input wire logic i_borrow_n,
  output logic o_count_up,
  output logic o_count_down,
  output logic o_load_n,
  output logic o_clear,
  output logic [3:0] o_data
);
  initial begin
    o_count_up = 1'b1;
    o_count_down = 1'b1;
    o_load_n = 1'b1;
    o_clear = 1'b0;
    o_data = 4'h0;
  end

  // Pulse one count pin, other held high; counts cycles carry or borrow sits low
  task automatic pulse(input logic up, input int w, output int n);
    n = 0;
    for (int k = 0; k < w + 8; k++) begin
      @(posedge i_clk);
      if (k == 0 && up) o_count_up <= 1'b0;
      if (k == 0 && !up) o_count_down <= 1'b0;
      if (k == w) begin
        o_count_up <= 1'b1;
        o_count_down <= 1'b1;
      end
      #1 n += int'(up ? !i_carry_n : !i_borrow_n);
    end
  endtask

  // Levels held four clocks so the synchroniser cannot miss them
  task automatic set(input logic ld, input logic cl, input logic [3:0] v);
    @(posedge i_clk);
    o_load_n <= ld;
    o_clear <= cl;
    o_data <= v;
    repeat (4) @(posedge i_clk);
    o_load_n <= 1'b1;
    o_clear <= 1'b0;
    o_data <= ~v;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
endmodule

// [dv/up_down_binary_counter_tb.sv]
// Purpose: Self-checking bench for the counter stage and a cascaded stage
// Assumes: Three clocks from pin change to count
// Notes: Results are noted in a queue and compared by a watcher
`timescale 1ns/1ns

module up_down_binary_counter_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cu, cd, ld_n, clr, cy_n, bw_n;
  logic [3:0] d, q, q2, v;
  logic [7:0] notes[$];
  logic [7:0] obs;
  event seen;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 4;
  int n, w;

  always #50 i_clk = ~i_clk;

  udc_drv drv (.i_clk(i_clk), .i_carry_n(cy_n), .i_borrow_n(bw_n), .o_count_up(cu),
    .o_count_down(cd), .o_load_n(ld_n), .o_clear(clr), .o_data(d));
  udc_counter dut (.i_clk(i_clk), .i_rst(i_rst), .i_count_up(cu), .i_count_down(cd),
    .i_load_n(ld_n), .i_clear(clr), .i_data(d), .o_q(q), .o_carry_n(cy_n),
    .o_borrow_n(bw_n));
  udc_counter dut_nxt (.i_clk(i_clk), .i_rst(i_rst), .i_count_up(cy_n), .i_count_down(bw_n),
    .i_load_n(1'b1), .i_clear(clr), .i_data(4'h0), .o_q(q2), .o_carry_n(),
    .o_borrow_n());

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic look(input logic [7:0] s, input logic [7:0] e);
    notes.push_back(e);
    obs = s;
    ->seen;
    #1;
  endtask

  always @(seen) chk(obs, notes.pop_front());

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ********************************************
  // Tests
  // ********************************************
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1 look(8'(q), 8'h0);
    look(8'({cy_n, bw_n}), 8'h3);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      v = 4'($random(seed));
      drv.set(1'b0, 1'b0, v);
      look(8'(q), 8'(v));
    end
    // Up edge lands while load is still low, so the preset must win
    v = 4'($random(seed));
    fork
      drv.set(1'b0, 1'b0, v);
      drv.pulse(1'b1, 2, n);
    join
    look(8'(q), 8'(v));
    $display("test load done");
    drv.set(1'b0, 1'b0, 4'he);
    drv.pulse(1'b1, 2, n);
    look(8'(q), 8'hf);
    look(8'(n), 8'h0);
    w = 2 + ($random(seed) & 3);
    drv.pulse(1'b1, w, n);
    look(8'(q), 8'h0);
    look(8'(n), 8'(w));
    look(8'(q2), 8'h1);
    drv.pulse(1'b0, 3, n);
    look(8'(q), 8'hf);
    look(8'(n), 8'h3);
    look(8'(q2), 8'h0);
    drv.pulse(1'b0, 2, n);
    look(8'(q), 8'he);
    look(8'(n), 8'h0);
    $display("test count done");
    drv.set(1'b0, 1'b1, 4'h9);
    look(8'(q), 8'h0);
    $display("test clear done");
    wrap_up();
  end

  // Whole run is about a hundred clocks
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
endmodule
